// file: verilog/asp_cfg.svh
// Purpose: Constants for the serial port with boot loader
// Assumes: 8-bit register port, 125 MHz mclk
// Notes:   Offsets are register indices on the local port
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_REG_FMT        2'h0
`define ASP_REG_TXC        2'h1
`define ASP_REG_RXC        2'h2
`define ASP_REG_DAT        2'h3
`define ASP_FMT_LOOP       7
`define ASP_FMT_RATE_HI    6
`define ASP_FMT_RATE_LO    5
`define ASP_FMT_CSEL       4
`define ASP_FMT_EVEN       3
`define ASP_FMT_PAR        2
`define ASP_FMT_LEN_HI     1
`define ASP_FMT_LEN_LO     0
`define ASP_TX_EMPTY       0
`define ASP_TX_LEVEL       1
`define ASP_TX_FORCE       2
`define ASP_TX_SPACE       3
`define ASP_TX_STOP2       4
`define ASP_TX_IRQ         5
`define ASP_TX_EN          7
`define ASP_RX_READY       0
`define ASP_RX_OVR         1
`define ASP_RX_PARF        2
`define ASP_RX_FRMF        3
`define ASP_RX_ERR         4
`define ASP_RX_IRQ         5
`define ASP_RX_EN          7
`define ASP_FMT_RESET      8'h00
`define ASP_FMT_BOOT       8'h27
`define ASP_TXC_RESET      8'h00
`define ASP_RXC_RESET      8'h00
`define ASP_RXC_BOOT       8'h80
`define ASP_BOOT_COUNT     9'h100
`define ASP_BOOT_ADDR      24'h00_0000
`define ASP_FIFO_DEPTH     16
`define ASP_FIFO_AW        4
`endif

// file: verilog/asp_pkg.sv
// Purpose: Types for the serial port with boot loader
// Assumes: Constants live in asp_cfg.svh
// Notes:   States only
`default_nettype none
package asp_pkg;
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01
   } asp_tx_t;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_BITS  = 2'b10,
      RX_GAP   = 2'b11
   } asp_rx_t;
endpackage
`default_nettype wire

// file: verilog/asp_fifo.sv
// Purpose: Receive character FIFO, flip-flop storage
// Assumes: Single clock, enable freezes all state
// Notes:   in_ready is low when full, out_valid low when empty
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
   parameter int W = 11,
   parameter int D = 16,
   parameter int A = 4
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic [A:0]        level
);
   logic [W-1:0] mem_q [D];
   logic [A-1:0] wr_q;
   logic [A-1:0] rd_q;
   logic [A:0]   cnt_q;
   logic         push;
   logic         pop;

   assign in_ready  = (cnt_q != D[A:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (ce && push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/asp_top.sv
// Purpose: Asynchronous serial port with reset-time boot loader
// Assumes: Register port is a local 2-bit index, 8-bit data, one-cycle strobes
// Notes:   Bit clock edges arrive as one-cycle pulses sampled on mclk
// Function
// - Loopback routes transmit data to receiver, external pin ignored.
// - Rate field divides bit clock by 1, 16, 32 or 64.
// - Clock select picks timer output pulse (1) or timer input (0).
// - Parity appended and checked, even when sense 1, kept below 8 bits.
// - Length field selects 5 to 8 data bits.
// - Transmit empty flag set after reset, cleared by load, read-only.
// - Force fill sends a constant level for a character time per load.
// - Hold spacing drives output low at once; clearing returns marking.
// - Transmitter sends one or two stops; receiver checks one.
// - Transmit interrupt requested while buffer empty and enabled.
// - Transmit disabled keeps marking; character in flight completes.
// - Fault summary is OR of parity, overrun and framing flags.
// - Missing stop sets framing flag and adds half bit before searching.
// - Parity fault latched until software clears it.
// - Overrun flags newest character; latched after read until cleared.
// - Character ready follows buffered data, cleared by reading data.
// - Receive interrupt on error or character available when enabled.
// - Receive enable starts reception after format is programmed.
// - Wait plus line 6 at reset release halts and sets boot format.
// - Boot moves 256 bytes to incrementing memory from address zero.
// - Receive error during boot drives transmit output low.
// - Start low must persist half a bit; data sampled mid-bit.
// - Idle output high; characters framed with start, parity, stops.
// - After 256 boot bytes the processor leaves halt, fetch at 0.
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module asp_top (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        boot_wait,
   input  wire logic        boot_line6,
   input  wire logic        tmr_in_tick,
   input  wire logic        tmr_out_tick,
   input  wire logic [1:0]  reg_idx,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   input  wire logic        rx_pin,
   output logic             tx_pin,
   output logic             tx_irq,
   output logic             rx_irq,
   output logic             cpu_halt,
   output logic             mem_wr,
   output logic [23:0]      mem_addr,
   output logic [7:0]       mem_wdata
);
   // ****************************************************
   // Registers
   // ****************************************************
   logic [7:0]  fmt_q;
   logic [7:0]  txc_q;
   logic [7:0]  rxc_q;
   logic        tx_empty_q;
   logic [7:0]  txbuf_q;
   logic        txbuf_force_q;
   logic        boot_q;
   logic        boot_seen_q;
   logic [8:0]  boot_cnt_q;
   logic        boot_fail_q;
   logic        par_lat_q;
   logic        ovr_lat_q;
   logic [7:0]  rdata_q;

   function automatic logic [3:0] data_bits(input logic [1:0] len);
      data_bits = 4'd5 + {2'b00, len};
   endfunction

   logic [1:0] len;
   logic       par_en;
   logic       even;
   assign len    = fmt_q[`ASP_FMT_LEN_HI:`ASP_FMT_LEN_LO];
   assign par_en = fmt_q[`ASP_FMT_PAR];
   assign even   = fmt_q[`ASP_FMT_EVEN];

   // ****************************************************
   // Bit clock and divider
   // ****************************************************
   logic       tick;
   logic [5:0] div_q;
   logic       bit_en;
   logic       half_en;
   logic [5:0] div_max;
   assign tick = fmt_q[`ASP_FMT_CSEL] ? tmr_out_tick : tmr_in_tick;
   always_comb begin
      unique case (fmt_q[`ASP_FMT_RATE_HI:`ASP_FMT_RATE_LO])
         2'b00: div_max = 6'd0;
         2'b01: div_max = 6'd15;
         2'b10: div_max = 6'd31;
         2'b11: div_max = 6'd63;
      endcase
   end
   // Free-running prescale; the receiver aligns its own phase counter below
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div_q <= '0;
      end else if (ce && tick) begin
         div_q <= (div_q >= div_max) ? 6'd0 : div_q + 6'd1;
      end
   end
   assign bit_en  = tick && (div_q >= div_max);
   assign half_en = tick;

   // ****************************************************
   // Register port
   // ****************************************************
   logic       fifo_ov;
   logic       rx_avail;
   logic [10:0] fifo_out;
   logic       frm_cur;
   logic       par_cur;
   logic       ovr_cur;
   logic       err_any;
   assign frm_cur = rx_avail && fifo_out[8];
   assign par_cur = rx_avail && fifo_out[9];
   assign ovr_cur = rx_avail && fifo_out[10];
   assign err_any = par_lat_q || par_cur || ovr_lat_q || frm_cur || ovr_cur;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         boot_seen_q <= 1'b0;
         boot_q      <= 1'b0;
         fmt_q       <= `ASP_FMT_RESET;
         txc_q       <= `ASP_TXC_RESET;
         rxc_q       <= `ASP_RXC_RESET;
      end else if (ce) begin
         boot_seen_q <= 1'b1;
         if (!boot_seen_q && boot_wait && boot_line6) begin
            boot_q <= 1'b1;
            fmt_q  <= `ASP_FMT_BOOT;
            rxc_q  <= `ASP_RXC_BOOT;
         end else if (boot_q && boot_cnt_q == `ASP_BOOT_COUNT) begin
            boot_q <= 1'b0;
         end
         if (reg_wr && !boot_q) begin
            unique case (reg_idx)
               `ASP_REG_FMT: fmt_q <= reg_wdata;
               `ASP_REG_TXC: txc_q <= {reg_wdata[7:1], 1'b0};
               `ASP_REG_RXC: rxc_q <= {reg_wdata[7:5], 5'b0};
               `ASP_REG_DAT: ;
            endcase
         end
      end
   end

   always_comb begin
      unique case (reg_idx)
         `ASP_REG_FMT: reg_rdata = fmt_q;
         `ASP_REG_TXC: reg_rdata = {txc_q[7:1], tx_empty_q};
         `ASP_REG_RXC: reg_rdata = {rxc_q[7:5], err_any, frm_cur,
                                    par_lat_q || par_cur, ovr_lat_q || ovr_cur, rx_avail};
         `ASP_REG_DAT: reg_rdata = rdata_q;
      endcase
   end

   // ****************************************************
   // Transmitter
   // ****************************************************
   asp_pkg::asp_tx_t tx_st_q;
   logic [11:0] tx_sh_q;
   logic [3:0]  tx_left_q;
   logic        tx_line_q;
   logic        tx_par;
   logic [7:0]  tx_mask;
   logic        tx_load;
   assign tx_load = reg_wr && reg_idx == `ASP_REG_DAT && !boot_q;
   assign tx_mask = txbuf_q & (8'hFF >> (3'd3 - {1'b0, len}));
   assign tx_par  = (^tx_mask) ^ ~even;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_empty_q    <= 1'b1;
         txbuf_q       <= '0;
         txbuf_force_q <= 1'b0;
         tx_st_q       <= asp_pkg::TX_IDLE;
         tx_sh_q       <= '1;
         tx_left_q     <= '0;
         tx_line_q     <= 1'b1;
      end else if (ce) begin
         if (tx_load) begin
            txbuf_q       <= reg_wdata;
            txbuf_force_q <= txc_q[`ASP_TX_FORCE];
            tx_empty_q    <= 1'b0;
         end
         unique case (tx_st_q)
            asp_pkg::TX_IDLE: begin
               tx_line_q <= 1'b1;
               if (!tx_empty_q && txc_q[`ASP_TX_EN] && bit_en) begin
                  tx_empty_q <= !tx_load;
                  tx_st_q    <= asp_pkg::TX_SHIFT;
                  tx_left_q  <= data_bits(len) + {3'b0, par_en} + {3'b0, txc_q[`ASP_TX_STOP2]} + 4'd1;
                  if (txbuf_force_q) begin
                     tx_line_q <= txc_q[`ASP_TX_LEVEL];
                     tx_sh_q   <= {12{txc_q[`ASP_TX_LEVEL]}};
                  end else begin
                     tx_line_q <= 1'b0;
                     tx_sh_q   <= ({4'hF, tx_mask} & ~(12'h001 << data_bits(len)))
                                  | ({11'b0, par_en ? tx_par : 1'b1} << data_bits(len))
                                  | (12'hFFF << (data_bits(len) + 4'd1));
                  end
               end
            end
            asp_pkg::TX_SHIFT: begin
               if (bit_en) begin
                  tx_line_q <= tx_sh_q[0];
                  tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                  tx_left_q <= tx_left_q - 4'd1;
                  if (tx_left_q == 4'd1) begin
                     tx_st_q <= asp_pkg::TX_IDLE;
                  end
               end
            end
            default: tx_st_q <= asp_pkg::TX_IDLE;
         endcase
      end
   end
   assign tx_pin = !(txc_q[`ASP_TX_SPACE] || boot_fail_q) && tx_line_q;
   assign tx_irq = txc_q[`ASP_TX_IRQ] && tx_empty_q;

   // ****************************************************
   // Receiver
   // ****************************************************
   asp_pkg::asp_rx_t rx_st_q;
   logic        rx_in;
   logic [6:0]  ph_q;
   logic [6:0]  half_max;
   logic [3:0]  rx_n_q;
   logic [9:0]  rx_sh_q;
   logic        rx_push;
   logic [10:0] rx_word;
   logic        fifo_ready;
   logic        fifo_pop;
   logic [4:0]  fifo_lvl;
   logic [3:0]  rx_total;
   logic        rx_par_bad;
   logic [7:0]  rx_char;
   logic        stop_ok;

   assign rx_in    = fmt_q[`ASP_FMT_LOOP] ? tx_pin : rx_pin;
   assign half_max = (div_max == 6'd0) ? 7'd0 : {2'b0, div_max[5:1]};
   assign rx_total = data_bits(len) + {3'b0, par_en};
   assign stop_ok  = rx_in;
   always_comb begin
      rx_char = rx_sh_q[8:1] | (8'hFF << rx_total);
      if (len == 2'b11) begin
         rx_char = rx_sh_q[8:1];
      end
   end
   assign rx_par_bad = par_en && ((^(rx_sh_q[9:1] & ~(9'h1FF << rx_total))) != ~even);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_st_q <= asp_pkg::RX_IDLE;
         ph_q    <= '0;
         rx_n_q  <= '0;
         rx_sh_q <= '0;
      end else if (ce) begin
         unique case (rx_st_q)
            asp_pkg::RX_IDLE: begin
               ph_q <= '0;
               if (rxc_q[`ASP_RX_EN] && !rx_in) begin
                  rx_st_q <= asp_pkg::RX_START;
               end
            end
            asp_pkg::RX_START: begin
               if (half_en) begin
                  ph_q <= ph_q + 7'd1;
                  if (ph_q >= half_max) begin
                     ph_q    <= '0;
                     rx_n_q  <= '0;
                     rx_sh_q <= '0;
                     rx_st_q <= rx_in ? asp_pkg::RX_IDLE : asp_pkg::RX_BITS;
                  end
               end
            end
            asp_pkg::RX_BITS: begin
               if (half_en) begin
                  ph_q <= ph_q + 7'd1;
                  if (ph_q >= {1'b0, div_max}) begin
                     ph_q    <= '0;
                     rx_n_q  <= rx_n_q + 4'd1;
                     if (rx_n_q == rx_total) begin
                        rx_st_q <= stop_ok ? asp_pkg::RX_IDLE : asp_pkg::RX_GAP;
                     end else begin
                        rx_sh_q <= (rx_sh_q >> 1) | ({9'b0, rx_in} << rx_total);
                     end
                  end
               end
            end
            asp_pkg::RX_GAP: begin
               if (half_en) begin
                  ph_q <= ph_q + 7'd1;
                  if (ph_q >= half_max) begin
                     rx_st_q <= asp_pkg::RX_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign rx_push = ce && rx_st_q == asp_pkg::RX_BITS && half_en
                    && ph_q >= {1'b0, div_max} && rx_n_q == rx_total;
   // Overrun marks the newest character once two are already waiting
   assign fifo_ov = fifo_lvl >= 5'd2;
   assign rx_word = {fifo_ov, rx_par_bad, !stop_ok, rx_char};

   asp_fifo #(.W(11), .D(`ASP_FIFO_DEPTH), .A(`ASP_FIFO_AW)) u_fifo (
      .mclk      (mclk),
      .rstn      (rstn),
      .ce        (ce),
      .in_valid  (rx_push),
      .in_ready  (fifo_ready),
      .in_data   (rx_word),
      .out_valid (rx_avail),
      .out_ready (fifo_pop),
      .out_data  (fifo_out),
      .level     (fifo_lvl)
   );
   assign fifo_pop = boot_q ? rx_avail : (reg_rd && reg_idx == `ASP_REG_DAT);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         par_lat_q <= 1'b0;
         ovr_lat_q <= 1'b0;
         rdata_q   <= '0;
      end else if (ce) begin
         if (reg_wr && reg_idx == `ASP_REG_RXC) begin
            par_lat_q <= 1'b0;
            ovr_lat_q <= 1'b0;
         end
         // Set wins over a clearing write in the same cycle
         if (fifo_pop && fifo_out[9]) begin
            par_lat_q <= 1'b1;
         end
         if ((fifo_pop && fifo_out[10]) || (rx_push && !fifo_ready)) begin
            ovr_lat_q <= 1'b1;
         end
         if (fifo_pop) begin
            rdata_q <= fifo_out[7:0];
         end
      end
   end
   assign rx_irq = rxc_q[`ASP_RX_IRQ] && (rx_avail || err_any);

   // ****************************************************
   // Boot loader transfer
   // ****************************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         boot_cnt_q  <= '0;
         boot_fail_q <= 1'b0;
         mem_wr      <= 1'b0;
         mem_addr    <= `ASP_BOOT_ADDR;
         mem_wdata   <= '0;
      end else if (ce) begin
         mem_wr <= 1'b0;
         if (boot_q && rx_avail) begin
            mem_wr     <= 1'b1;
            mem_wdata  <= fifo_out[7:0];
            mem_addr   <= `ASP_BOOT_ADDR + {15'b0, boot_cnt_q};
            boot_cnt_q <= boot_cnt_q + 9'd1;
            if (|fifo_out[10:8]) begin
               boot_fail_q <= 1'b1;
            end
         end
      end
   end
   assign cpu_halt = boot_q;
endmodule
`default_nettype wire

// file: tb/asp_monitor.sv
// Purpose: Port checks for the serial port with boot loader
// Assumes: reg_rdata is a combinational view of the indexed register
// Notes:   The boot write counter is the only helper state
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module asp_monitor (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        boot_wait,
   input wire logic        boot_line6,
   input wire logic [1:0]  reg_idx,
   input wire logic [7:0]  reg_rdata,
   input wire logic        tx_pin,
   input wire logic        tx_irq,
   input wire logic        rx_irq,
   input wire logic        cpu_halt,
   input wire logic        mem_wr,
   input wire logic [23:0] mem_addr
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [8:0] nwr_q;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) nwr_q <= 9'h000;
      else if (mem_wr) nwr_q <= nwr_q + 9'h001;
   end
   chk_tx_irq_level: assert property (reg_idx == 2'h1 |-> tx_irq == (reg_rdata[5] & reg_rdata[0]))
      else $error("tx irq wrong");
   chk_err_summary: assert property (reg_idx == 2'h2 |-> reg_rdata[4] == (|reg_rdata[3:1]))
      else $error("error summary wrong");
   chk_rx_irq_level: assert property (reg_idx == 2'h2 |-> rx_irq == (reg_rdata[5] & (reg_rdata[0] | reg_rdata[4])))
      else $error("rx irq wrong");
   chk_break_low: assert property (reg_idx == 2'h1 && reg_rdata[3] |-> !tx_pin)
      else $error("break not spacing");
   chk_boot_strap: assert property ($rose(cpu_halt) |-> $past(boot_wait & boot_line6))
      else $error("halt without straps");
   chk_boot_format: assert property (cpu_halt && reg_idx == 2'h0 |-> reg_rdata == `ASP_FMT_BOOT)
      else $error("boot format wrong");
   chk_boot_addr: assert property (mem_wr |-> mem_addr == {15'h0000, nwr_q})
      else $error("boot address wrong");
   chk_boot_done: assert property ($fell(cpu_halt) |-> nwr_q == 9'h100 || (nwr_q == 9'h0ff && mem_wr))
      else $error("halt left early");
   cover property ($fell(cpu_halt));
   cover property (rx_irq && reg_idx == 2'h2 && reg_rdata[1]);
   cover property (reg_idx == 2'h1 && reg_rdata[3]);
endmodule
bind asp_top asp_monitor asp_monitor_i (
   .mclk(mclk), .rstn(rstn), .boot_wait(boot_wait), .boot_line6(boot_line6), .reg_idx(reg_idx),
   .reg_rdata(reg_rdata), .tx_pin(tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq), .cpu_halt(cpu_halt),
   .mem_wr(mem_wr), .mem_addr(mem_addr)
);
`default_nettype wire

// file: tb/asp_remote.sv
// Purpose: Remote serial sender and line sampler
// Assumes: Bit time is a whole number of mclk cycles
// Notes:   Frames are LSB first, index 0 is the start bit
`timescale 1ns/1ps
`default_nettype none
module asp_remote (
   input  wire logic mclk,
   input  wire logic tx_pin,
   output logic      rx_pin
);
   // ****************************************
   // Line model
   // ****************************************
   logic line = 1'b1;
   assign rx_pin = line;
   // Whole bit periods keep the far side in step with the divided clock
   task automatic send(input int bitc, input logic [15:0] f, input int nb);
      for (int k = 0; k <= nb; k++) begin
         line <= (k < nb) ? f[k] : 1'b1;
         repeat ((k < nb) ? bitc : 1) @(posedge mclk);
      end
   endtask
   // Unsampled tail stays at mark, so short frames compare with idle ones
   task automatic grab(input int bitc, input int nb, output logic [15:0] f);
      f = 16'hffff;
      for (int t = 0; t < 4000 && tx_pin !== 1'b0; t++) @(posedge mclk);
      repeat (bitc / 2) @(posedge mclk);
      for (int k = 0; k < nb; k++) begin
         f[k] = tx_pin;
         repeat (bitc) @(posedge mclk);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: Self-checking bench for the serial port with boot loader
// Assumes: Timer input ticks every clock, timer output every second clock
// Notes:   Divide-by-1 is left out, it needs outside bit sync
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module testbench;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        boot = 1'b1;
   logic        tout = 1'b0;
   logic [1:0]  reg_idx = 2'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata, mem_wdata;
   logic        rx_pin, tx_pin, tx_irq, rx_irq, cpu_halt, mem_wr;
   logic [23:0] mem_addr;
   int          n_mismatch = 0, num_checks = 0, cyc = 0, nwr = 0;
   logic [7:0]  sent[$];
   always #4 mclk = ~mclk;
   always @(posedge mclk) tout <= ~tout;
   asp_top asp_top_i (.mclk(mclk), .rstn(rstn), .ce(1'b1), .boot_wait(boot), .boot_line6(boot),
      .tmr_in_tick(1'b1), .tmr_out_tick(tout), .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_irq(tx_irq),
      .rx_irq(rx_irq), .cpu_halt(cpu_halt), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
   asp_remote asp_remote_i (.mclk(mclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 99000) begin
         cmp(24'h0, 24'h1, "timeout");
         stop_test;
      end
   end
   always @(negedge mclk) if (mem_wr === 1'b1) begin
      cmp(mem_addr, 24'(nwr), "boot addr");
      cmp(24'(mem_wdata), 24'(sent[nwr]), "boot byte");
      nwr++;
   end
   task automatic wr(input logic [1:0] i, input logic [7:0] d);
      reg_idx <= i;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [1:0] i, input logic s, output logic [7:0] d);
      reg_idx <= i;
      reg_rd <= s;
      @(negedge mclk);
      d = reg_rdata;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic poll(input logic [1:0] i, output logic [7:0] v);
      for (int t = 0; t < 3000; t++) begin
         rd(i, 1'b0, v);
         if (v[0] === 1'b1) break;
      end
   endtask
   // Status is read before the pop, then the popped char is viewed
   task automatic getc(output logic [7:0] st, output logic [7:0] ch);
      poll(2'h2, st);
      rd(2'h3, 1'b1, ch);
      rd(2'h3, 1'b0, ch);
   endtask
   task automatic quiet(input int c);
      int lo = 0;
      repeat (c) begin
         @(negedge mclk);
         lo += int'(tx_pin !== 1'b1);
      end
      cmp(24'(lo), 24'h0, "line left mark");
   endtask
   function automatic logic [15:0] frm(logic [7:0] d, int n, logic p, logic ev);
      logic [7:0]  m;
      logic [15:0] f;
      m = 8'hff >> (8 - n);
      f = {7'h7f, (d & m) | ~m, 1'b0};
      if (p) f[n + 1] = ^(d & m) ^ ~ev;
      return f;
   endfunction
   function automatic logic [7:0] chx(logic [7:0] d, int n, logic p, logic ev);
      logic [15:0] f;
      f = frm(d, n, p, ev);
      return (p && n < 8) ? f[8:1] : (d | (8'hff << n));
   endfunction
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      logic [7:0]  st, ch, d, d2, e;
      logic [15:0] f;
      int          n, bitc, len;
      logic        lp, p, ev, s2, cs;
      logic [1:0]  rt;
      void'($urandom(32'hd46c));
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      cmp(24'(cpu_halt), 24'h1, "halt");
      boot <= 1'b0;
      repeat (20) @(posedge mclk);
      wr(2'h0, 8'h00);
      rd(2'h0, 1'b0, st);
      cmp(24'(st), 24'(`ASP_FMT_BOOT), "boot fmt");
      rd(2'h2, 1'b0, st);
      cmp(24'(st), 24'(`ASP_RXC_BOOT), "boot rx");
      rd(2'h1, 1'b0, st);
      cmp(24'(st), 24'h1, "tx reset");
      for (int k = 0; k < 256; k++) begin
         sent.push_back(8'($urandom));
         asp_remote_i.send(16, frm(sent[k], 8, 1'b1, 1'b0), 11);
      end
      for (int t = 0; t < 400 && cpu_halt; t++) @(posedge mclk);
      cmp(24'({cpu_halt, 9'(nwr)}), 24'h100, "boot end");
      $display("test boot finished");
      for (int i = 0; i < 6; i++) begin
         lp = i[0];
         {p, ev, s2, cs} = 4'($urandom);
         {d, d2, e} = 24'($urandom);
         n = 5 + $urandom % 4;
         rt = 2'(1 + $urandom % 3);
         bitc = (8 << rt) * (cs ? 2 : 1);
         len = 2 + n + p + s2;
         wr(2'h0, {lp, rt, cs, ev, p, 2'(n - 5)});
         wr(2'h1, {3'h4, s2, 4'h0});
         wr(2'h2, 8'h80);
         if (lp) asp_remote_i.line <= 1'b0;
         fork
            if (!lp) asp_remote_i.grab(bitc, 16, f);
            if (!lp) asp_remote_i.send(bitc, frm(e, n, p, ev), len - s2);
            begin
               wr(2'h3, d);
               if (!lp) poll(2'h1, st);
               if (!lp) wr(2'h3, d2);
            end
         join
         if (!lp) cmp(24'(f), 24'(frm(d, n, p, ev) & (frm(d2, n, p, ev) << len | ~(16'hffff << len))), "frame");
         repeat (13 * bitc) @(posedge mclk);
         getc(st, ch);
         cmp(24'(st), 24'h81, "rx status");
         cmp(24'(ch), 24'(chx(lp ? d : e, n, p, ev)), "rx char");
         rd(2'h2, 1'b0, st);
         cmp(24'(st), 24'h80, "ready after read");
         asp_remote_i.line <= 1'b1;
      end
      $display("test format finished");
      wr(2'h0, 8'h2e);
      wr(2'h1, 8'h00);
      wr(2'h3, d);
      wr(2'h1, 8'h01);
      rd(2'h1, 1'b0, st);
      cmp(24'(st), 24'h0, "empty write");
      quiet(300);
      fork
         asp_remote_i.grab(16, 16, f);
         wr(2'h1, 8'h80);
      join
      cmp(24'(f), 24'(frm(d, 7, 1'b1, 1'b1)), "held char");
      wr(2'h3, d);
      repeat (48) @(posedge mclk);
      wr(2'h1, 8'ha8);
      cmp(24'(tx_pin), 24'h0, "break");
      poll(2'h1, st);
      cmp(24'(tx_irq), 24'h1, "tx irq");
      wr(2'h1, 8'h80);
      repeat (200) @(posedge mclk);
      cmp(24'({tx_pin, tx_irq}), 24'h2, "mark no irq");
      fork
         asp_remote_i.grab(16, 16, f);
         begin
            wr(2'h1, 8'h84);
            wr(2'h3, d);
         end
      join
      cmp(24'(f[7:0]), 24'h0, "forced space");
      wr(2'h1, 8'h86);
      wr(2'h3, d);
      quiet(200);
      $display("test tx control finished");
      wr(2'h2, 8'ha0);
      asp_remote_i.send(16, frm(e, 7, 1'b1, 1'b1) ^ 16'h0200, 10);
      getc(st, ch);
      cmp(24'(st), 24'hb9, "frame fault");
      asp_remote_i.send(16, frm(e, 7, 1'b1, 1'b1) ^ 16'h0100, 10);
      getc(st, ch);
      cmp(24'(st), 24'hb5, "parity fault");
      rd(2'h2, 1'b0, st);
      cmp(24'(st), 24'hb4, "parity latch");
      wr(2'h2, 8'hbf);
      rd(2'h2, 1'b0, st);
      cmp(24'(st), 24'ha0, "cleared");
      for (int k = 0; k < 3; k++) asp_remote_i.send(16, frm(8'(k), 7, 1'b1, 1'b1), 10);
      repeat (3) getc(st, ch);
      cmp(24'(ch), 24'(chx(8'h02, 7, 1'b1, 1'b1)), "third char");
      rd(2'h2, 1'b0, st);
      cmp(24'(st), 24'hb2, "overrun latch");
      $display("test rx faults finished");
      stop_test;
   end
endmodule
`default_nettype wire
